// ---- src/mac_pkg.sv ----
/*
 * shared constants and types of the multiply/accumulate datapath.
 * assumes one core clock domain; bit 0 of every vector is the lsb.
 */
package mac_pkg;

    // ==================================================
    // widths
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int PROD_W = 64;
    localparam int GUARD_W = 4;
    localparam int ACC_W = 68;
    localparam int DEST_W = 5;

    // ==================================================
    // field positions of the halfword operands
    localparam int HALF_INT_POS = 0;
    localparam int HALF_FRAC_POS = 16;

    // ==================================================
    // rounding constants and shift
    localparam logic [ACC_W-1:0] HW_ROUND_CONST = 68'h0_0000_0000_0000_8000;
    localparam logic [ACC_W-1:0] WORD_ROUND_CONST = 68'h0_0000_0000_8000_0000;
    localparam int FRAC_SHIFT = 1;

    // ==================================================
    // reset values and timing
    localparam logic [ACC_W-1:0] ACC_RESET = 68'h0_0000_0000_0000_0000;
    localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
    localparam int PIPE_LATENCY = 2;

    // ==================================================
    // operations
    typedef enum logic [3:0] {
        OP_HW_SUB = 4'h1,
        OP_WORD_MAC = 4'h2,
        OP_WORD_SUB = 4'h4,
        OP_WORD_SUB_U = 4'h8
    } op_type;

endpackage

// ---- src/mult_if.sv ----
/*
 * carrier between the accumulator control and the multiplier stage.
 * assumes both ends sit on the same core clock.
 */
`timescale 1ns/1ps
interface mult_if;
    import mac_pkg::*;
    logic [WORD_W-1:0] op_a;
    logic [WORD_W-1:0] op_b;
    logic is_signed;
    logic op_valid;
    logic [PROD_W-1:0] prod;
    logic prod_valid;

    modport requester (
        output op_a, op_b, is_signed, op_valid,
        input prod, prod_valid
    );
    modport multiplier (
        input op_a, op_b, is_signed, op_valid,
        output prod, prod_valid
    );
endinterface

// ---- src/mult_stage.sv ----
/*
 * one registered 32x32 multiplier, signed or unsigned per request.
 * assumes operands arrive from logic on the same clock.
 */
`timescale 1ns/1ps
module mult_stage (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // operand and product carrier
    mult_if.multiplier mul
);
    import mac_pkg::*;

    // ==================================================
    // product
    logic signed [WORD_W:0] ext_a;
    logic signed [WORD_W:0] ext_b;
    logic signed [2*WORD_W+1:0] full_prod;
    logic [PROD_W-1:0] prod_r;
    logic prod_valid_r;

    assign ext_a = $signed({mul.is_signed & mul.op_a[WORD_W-1], mul.op_a});
    assign ext_b = $signed({mul.is_signed & mul.op_b[WORD_W-1], mul.op_b});
    assign full_prod = ext_a * ext_b;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prod_r <= 64'h0000_0000_0000_0000;
            prod_valid_r <= 1'b0;
        end else begin
            prod_r <= full_prod[PROD_W-1:0];
            prod_valid_r <= mul.op_valid;
        end
    end

    assign mul.prod = prod_r;
    assign mul.prod_valid = prod_valid_r;
endmodule // mult_stage

// ---- src/mac_unit.sv ----
/*
 * multiply/accumulate/subtract datapath with a 68-bit accumulator.
 * assumes decode presents one request per cycle on the core clock;
 * results appear two cycles after a request is taken.
 */
`timescale 1ns/1ps
module mac_unit (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // request from decode
    input wire logic req_valid,
    input wire mac_pkg::op_type req_op,
    input wire logic fraction_mode_bit,
    input wire logic req_round,
    input wire logic [mac_pkg::WORD_W-1:0] general_register_a,
    input wire logic [mac_pkg::WORD_W-1:0] general_register_b,
    input wire logic [mac_pkg::DEST_W-1:0] req_dest_idx,
    input wire logic acc_clear,
    // word result to the register file
    output logic res_valid,
    output logic [mac_pkg::DEST_W-1:0] res_dest_idx,
    output logic [mac_pkg::WORD_W-1:0] res_word,
    // accumulator view
    output logic [mac_pkg::WORD_W-1:0] acc_high_word,
    output logic [mac_pkg::WORD_W-1:0] acc_low_word,
    output logic [mac_pkg::GUARD_W-1:0] acc_guard
);
    import mac_pkg::*;

    mult_if mul ();

    // ==================================================
    // operand selection
    logic req_hw;
    logic [HALF_W-1:0] half_a;
    logic [HALF_W-1:0] half_b;
    assign req_hw = (req_op == OP_HW_SUB);
    assign half_a = fraction_mode_bit ? general_register_a[HALF_FRAC_POS +: HALF_W]
                                      : general_register_a[HALF_INT_POS +: HALF_W];
    assign half_b = fraction_mode_bit ? general_register_b[HALF_FRAC_POS +: HALF_W]
                                      : general_register_b[HALF_INT_POS +: HALF_W];
    assign mul.op_a = req_hw ? {{HALF_W{half_a[HALF_W-1]}}, half_a} : general_register_a;
    assign mul.op_b = req_hw ? {{HALF_W{half_b[HALF_W-1]}}, half_b} : general_register_b;
    assign mul.is_signed = (req_op != OP_WORD_SUB_U);
    assign mul.op_valid = req_valid;

    mult_stage u_mult (
        .sys_clk(sys_clk),
        .rst(rst),
        .mul(mul)
    );

    // ==================================================
    // control carried beside the multiplier
    op_type s1_op_r;
    logic s1_frac_r;
    logic s1_round_r;
    logic [DEST_W-1:0] s1_dest_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_op_r <= OP_HW_SUB;
            s1_frac_r <= 1'b0;
            s1_round_r <= 1'b0;
            s1_dest_r <= 5'h00;
        end else begin
            s1_op_r <= req_op;
            s1_frac_r <= fraction_mode_bit;
            s1_round_r <= req_round;
            s1_dest_r <= req_dest_idx;
        end
    end

    // ==================================================
    // accumulate
    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] acc_nxt;
    logic [ACC_W-1:0] acc_base;
    logic [ACC_W-1:0] prod_ext;
    logic [ACC_W-1:0] prod_sh;
    logic [ACC_W-1:0] round_const;
    logic [ACC_W-1:0] sum;
    logic s1_hw;
    logic s1_sub;
    logic [WORD_W-1:0] word_nxt;
    logic [WORD_W-1:0] res_word_r;
    logic [DEST_W-1:0] res_dest_r;
    logic res_valid_r;

    assign s1_hw = (s1_op_r == OP_HW_SUB);
    assign s1_sub = (s1_op_r != OP_WORD_MAC);
    assign prod_ext = (s1_op_r == OP_WORD_SUB_U) ? {{GUARD_W{1'b0}}, mul.prod}
                                                 : {{GUARD_W{mul.prod[PROD_W-1]}}, mul.prod};
    assign prod_sh = s1_frac_r ? (prod_ext << FRAC_SHIFT) : prod_ext;
    assign round_const = !s1_round_r ? ACC_RESET
                       : s1_hw ? HW_ROUND_CONST : WORD_ROUND_CONST;
    assign acc_base = acc_clear ? ACC_RESET : acc_r;
    assign sum = s1_sub ? (acc_base - prod_sh + round_const)
                        : (acc_base + prod_sh + round_const);
    assign acc_nxt = mul.prod_valid ? sum : acc_base;
    assign word_nxt = (s1_round_r && !s1_hw) ? sum[2*WORD_W-1:WORD_W]
                    : (s1_round_r && s1_hw) ? {sum[WORD_W-1:HALF_W], 16'h0000}
                    : sum[WORD_W-1:0];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc_r <= ACC_RESET;
            res_valid_r <= 1'b0;
            res_word_r <= WORD_RESET;
            res_dest_r <= 5'h00;
        end else begin
            acc_r <= acc_nxt;
            res_valid_r <= mul.prod_valid;
            if (mul.prod_valid) begin
                res_word_r <= word_nxt;
                res_dest_r <= s1_dest_r;
            end
        end
    end

    assign res_valid = res_valid_r;
    assign res_word = res_word_r;
    assign res_dest_idx = res_dest_r;
    assign acc_high_word = acc_r[2*WORD_W-1:WORD_W];
    assign acc_low_word = acc_r[WORD_W-1:0];
    assign acc_guard = acc_r[ACC_W-1:PROD_W];

    // ==================================================
    // checks
    logic [ACC_W-1:0] chk_ws;
    logic [ACC_W-1:0] chk_wu;
    logic [ACC_W-1:0] chk_hi;
    logic [ACC_W-1:0] chk_hf;
    logic [WORD_W-1:0] ga;
    logic [WORD_W-1:0] gb;
    logic clean;
    assign ga = general_register_a;
    assign gb = general_register_b;
    assign chk_ws = $signed({{36{ga[31]}}, ga}) * $signed({{36{gb[31]}}, gb});
    assign chk_wu = {36'h0_0000_0000, ga} * {36'h0_0000_0000, gb};
    assign chk_hi = $signed({{52{ga[15]}}, ga[15:0]}) * $signed({{52{gb[15]}}, gb[15:0]});
    assign chk_hf = $signed({{52{ga[31]}}, ga[31:16]}) * $signed({{52{gb[31]}}, gb[31:16]});
    logic clear_seen_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clear_seen_r <= 1'b0;
        end else begin
            clear_seen_r <= acc_clear;
        end
    end

    assign clean = res_valid && !clear_seen_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_result_latency: assert property (req_valid |-> ##2 res_valid)
        else $error("result not two cycles after request");
    a_hw_sub_int: assert property (
        clean && $past(req_op, 2) == OP_HW_SUB && !$past(fraction_mode_bit, 2)
        && !$past(req_round, 2) |-> acc_r == $past(acc_r) - $past(chk_hi, 2))
        else $error("halfword subtract result wrong");
    a_hw_frac_sel: assert property (
        clean && $past(req_op, 2) == OP_HW_SUB && $past(fraction_mode_bit, 2)
        && !$past(req_round, 2) |-> acc_r == $past(acc_r) - ($past(chk_hf, 2) << 1))
        else $error("fraction halfword select or shift wrong");
    a_hw_round_val: assert property (
        clean && $past(req_op, 2) == OP_HW_SUB && !$past(fraction_mode_bit, 2)
        && $past(req_round, 2) |-> acc_r == $past(acc_r) - $past(chk_hi, 2) + 68'h8000
        && res_word[15:0] == 16'h0000)
        else $error("halfword rounding wrong");
    a_word_mac_int: assert property (
        clean && $past(req_op, 2) == OP_WORD_MAC && !$past(fraction_mode_bit, 2)
        && !$past(req_round, 2) |-> acc_r == $past(acc_r) + $past(chk_ws, 2))
        else $error("word accumulate wrong");
    a_word_sub_int: assert property (
        clean && $past(req_op, 2) == OP_WORD_SUB && !$past(fraction_mode_bit, 2)
        && !$past(req_round, 2) |-> acc_r == $past(acc_r) - $past(chk_ws, 2))
        else $error("word subtract wrong");
    a_word_round_dest: assert property (
        res_valid && $past(req_op, 2) != OP_HW_SUB && $past(req_round, 2)
        |-> res_word == acc_high_word && res_word == $past(acc_nxt[63:32]))
        else $error("rounded word result not high word");
    a_word_frac_mac: assert property (
        clean && $past(req_op, 2) == OP_WORD_MAC && $past(fraction_mode_bit, 2)
        && !$past(req_round, 2) |-> acc_r == $past(acc_r) + ($past(chk_ws, 2) << 1))
        else $error("fraction word shift wrong");
    a_unsigned_sub: assert property (
        clean && $past(req_op, 2) == OP_WORD_SUB_U && !$past(fraction_mode_bit, 2)
        && !$past(req_round, 2) |-> acc_r == $past(acc_r) - $past(chk_wu, 2))
        else $error("unsigned word subtract wrong");
    a_guard_sign_ext: assert property (
        clean && $past(req_op, 2) == OP_HW_SUB
        && ($past(acc_r[67:56]) == 12'h000 || $past(acc_r[67:56]) == 12'hFFF)
        |-> acc_guard == {4{acc_high_word[31]}})
        else $error("guard bits not sign extension");
    a_int_dest_low: assert property (
        res_valid && !$past(req_round, 2) |-> res_word == acc_low_word)
        else $error("unrounded result not low word");
    a_word_round_val: assert property (
        clean && $past(req_op, 2) == OP_WORD_MAC && !$past(fraction_mode_bit, 2)
        && $past(req_round, 2)
        |-> acc_r == $past(acc_r) + $past(chk_ws, 2) + WORD_ROUND_CONST)
        else $error("word rounding wrong");
    a_word_sub_frac: assert property (
        clean && $past(req_op, 2) == OP_WORD_SUB && $past(fraction_mode_bit, 2)
        && !$past(req_round, 2) |-> acc_r == $past(acc_r) - ($past(chk_ws, 2) << 1))
        else $error("fraction word subtract shift wrong");
    a_dest_carry: assert property (res_valid |-> res_dest_idx == $past(req_dest_idx, 2))
        else $error("destination index not carried");

    c_hw_sub: cover property (res_valid && $past(req_op, 2) == OP_HW_SUB);
    c_word_round: cover property (res_valid && $past(req_op, 2) == OP_WORD_MAC
        && $past(req_round, 2));
    c_unsigned: cover property (res_valid && $past(req_op, 2) == OP_WORD_SUB_U);
    c_back_to_back: cover property (res_valid [*3]);
    c_clear_landing: cover property (res_valid && clear_seen_r);
endmodule // mac_unit

// ---- dv/decode_model.sv ----
/*
 * decode-side partner: launches request groups into the datapath.
 * assumes requests change just after a rising edge of sys_clk.
 */
`timescale 1ns/1ps
module decode_model (
    // clock
    input wire logic sys_clk,
    // request group
    output logic req_valid,
    output mac_pkg::op_type req_op,
    output logic fraction_mode_bit,
    output logic req_round,
    output logic [mac_pkg::WORD_W-1:0] general_register_a,
    output logic [mac_pkg::WORD_W-1:0] general_register_b,
    output logic [mac_pkg::DEST_W-1:0] req_dest_idx,
    output logic acc_clear
);
    import mac_pkg::*;
    // ====
    // idle values
    initial begin
        {req_valid, fraction_mode_bit, req_round, acc_clear} = 4'h0;
        req_op = OP_WORD_MAC;
        general_register_a = 32'h0000_0000;
        general_register_b = 32'h0000_0000;
        req_dest_idx = 5'h00;
    end
    // ====
    // one request per call, held until the next call
    task automatic issue(input op_type op, input logic frac, input logic rnd,
        input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b,
        input logic [DEST_W-1:0] dest, input logic clr);
        @(posedge sys_clk);
        #1;
        {req_valid, fraction_mode_bit, req_round, acc_clear} = {1'b1, frac, rnd, clr};
        req_op = op;
        general_register_a = a;
        general_register_b = b;
        req_dest_idx = dest;
    endtask
    // released sources show inverted junk
    task automatic idle(input logic clr);
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        acc_clear = clr;
        general_register_a = ~general_register_a;
        general_register_b = ~general_register_b;
    endtask
endmodule // decode_model

// ---- dv/mac_unit_tb.sv ----
/*
 * self-checking bench of the multiply/accumulate datapath.
 * assumes results two cycles after a taken request.
 */
`timescale 1ns/1ps
module mac_unit_tb;
    import mac_pkg::*;
    typedef struct {
        logic [WORD_W-1:0] word;
        logic [DEST_W-1:0] dest;
        logic [ACC_W-1:0] acc;
        int cyc;
    } exp_type;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid, fraction_mode_bit, req_round, acc_clear, res_valid;
    op_type req_op;
    logic [WORD_W-1:0] general_register_a, general_register_b;
    logic [WORD_W-1:0] res_word, acc_high_word, acc_low_word;
    logic [DEST_W-1:0] req_dest_idx, res_dest_idx;
    logic [GUARD_W-1:0] acc_guard;
    logic [ACC_W-1:0] acc_m = ACC_RESET;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    exp_type pend[$];
    exp_type got;
    // ====
    // clock and cycle count
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    decode_model u_decode_model (.sys_clk(sys_clk), .req_valid(req_valid), .req_op(req_op),
        .fraction_mode_bit(fraction_mode_bit), .req_round(req_round),
        .general_register_a(general_register_a), .general_register_b(general_register_b),
        .req_dest_idx(req_dest_idx), .acc_clear(acc_clear));
    mac_unit u_mac_unit (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
        .req_op(req_op), .fraction_mode_bit(fraction_mode_bit), .req_round(req_round),
        .general_register_a(general_register_a), .general_register_b(general_register_b),
        .req_dest_idx(req_dest_idx), .acc_clear(acc_clear), .res_valid(res_valid),
        .res_dest_idx(res_dest_idx), .res_word(res_word), .acc_high_word(acc_high_word),
        .acc_low_word(acc_low_word), .acc_guard(acc_guard));
    // ====
    // checking helpers
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    function automatic logic [ACC_W-1:0] product(input op_type op, input logic frac,
        input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
        logic signed [HALF_W-1:0] ha;
        logic signed [HALF_W-1:0] hb;
        logic signed [ACC_W-1:0] p;
        ha = frac ? a[HALF_FRAC_POS +: HALF_W] : a[HALF_INT_POS +: HALF_W];
        hb = frac ? b[HALF_FRAC_POS +: HALF_W] : b[HALF_INT_POS +: HALF_W];
        if (op == OP_HW_SUB) p = ha * hb;
        else if (op == OP_WORD_SUB_U) p = a * b;
        else p = $signed(a) * $signed(b);
        return p << frac;
    endfunction
    task automatic send(input op_type op, input logic frac, input logic rnd,
        input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b,
        input logic [DEST_W-1:0] dest, input logic clr);
        exp_type e;
        logic [ACC_W-1:0] base;
        u_decode_model.issue(op, frac, rnd, a, b, dest, clr);
        base = clr ? ACC_RESET : acc_m;
        acc_m = (op == OP_WORD_MAC) ? base + product(op, frac, a, b)
            : base - product(op, frac, a, b);
        if (rnd) acc_m = acc_m + ((op == OP_HW_SUB) ? HW_ROUND_CONST : WORD_ROUND_CONST);
        e.word = !rnd ? acc_m[31:0] : (op == OP_HW_SUB) ? {acc_m[31:16], 16'h0000}
            : acc_m[63:32];
        e.dest = dest;
        e.acc = acc_m;
        e.cyc = cyc + 2;
        pend.push_back(e);
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (pend.size() != 0 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        #1;
        check(pend.size() == 0, "result missing");
        if (pend.size() != 0) conclude();
    endtask
    // ====
    // result monitor
    always @(negedge sys_clk) begin
        if (res_valid === 1'b1) begin
            check(pend.size() != 0, "unexpected result");
            if (pend.size() != 0) begin
                got = pend.pop_front();
                check(cyc == got.cyc, "result latency");
                check(res_word === got.word, "word result");
                check(res_dest_idx === got.dest, "destination index");
                check({acc_guard, acc_high_word, acc_low_word} === got.acc, "accumulator");
            end
        end
    end
    // ====
    // scenarios
    task automatic t_modes();
        op_type ops[4] = '{OP_HW_SUB, OP_WORD_MAC, OP_WORD_SUB, OP_WORD_SUB_U};
        for (int i = 0; i < 16; i++) begin
            send(ops[i/4], i[1], i[0], 32'hC001_7FF3 ^ (i * 32'h0101_0101),
                32'h7FFE_8005 + i, i[4:0], 1'b0);
        end
        u_decode_model.idle(1'b0);
        drain();
        $display("test modes done");
    endtask
    task automatic t_clear_round();
        send(OP_HW_SUB, 1'b0, 1'b1, 32'h0000_0001, 32'h0000_8000, 5'h1F, 1'b1);
        u_decode_model.idle(1'b1);
        u_decode_model.idle(1'b0);
        drain();
        check(res_word === 32'h0001_0000, "halfword rounding");
        $display("test clear and round done");
    endtask
    task automatic t_guard();
        send(OP_WORD_MAC, 1'b1, 1'b0, 32'h8000_0000, 32'h8000_0000, 5'h0A, 1'b1);
        u_decode_model.idle(1'b1);
        u_decode_model.idle(1'b0);
        drain();
        send(OP_WORD_MAC, 1'b1, 1'b0, 32'h8000_0000, 32'h8000_0000, 5'h0B, 1'b0);
        send(OP_WORD_MAC, 1'b1, 1'b0, 32'h8000_0000, 32'h8000_0000, 5'h14, 1'b0);
        u_decode_model.idle(1'b0);
        drain();
        check(acc_guard === 4'h1 && acc_high_word === 32'h8000_0000, "guard bits");
        $display("test guard done");
    endtask
    task automatic t_reset();
        @(posedge sys_clk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        acc_m = ACC_RESET;
        check(res_valid === 1'b0 && res_word === WORD_RESET
            && res_dest_idx === 5'h00, "reset outputs");
        check({acc_guard, acc_high_word, acc_low_word} === ACC_RESET, "reset accumulator");
        $display("test reset done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        t_modes();
        t_clear_round();
        t_guard();
        t_reset();
        t_modes();
        conclude();
    end
endmodule // mac_unit_tb
